// ==== verilog/interrupt_request_front_end.sv ====
`timescale 1ns/1ps
module interrupt_request_front_end
   import irq_front_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic nmi_request,
   input wire logic maskable_request_zero,
   input wire logic maskable_request_one,
   input wire logic request_two_or_ack_zero_in,
   output logic request_two_or_ack_zero_out,
   output logic request_two_or_ack_zero_oe,
   input wire logic request_three_or_ack_one_in,
   output logic request_three_or_ack_one_out,
   output logic request_three_or_ack_one_oe,
   input wire logic instr_boundary,
   input wire logic end_of_service,
   output logic take_valid,
   output logic take_nmi,
   output logic [7:0] take_vector,
   output logic irq
);
   // software state
   logic [CFG_WIDTH-1:0] config_reg;
   logic [NUM_LINES-1:0] enable_reg;
   logic [EVT_WIDTH-1:0] evt_status;
   logic [EVT_WIDTH-1:0] evt_mask;
   logic [7:0] vector_base;
   // bus data phase
   logic dp_write;
   logic [7:0] dp_addr;
   // synchronized pins
   logic [SYNC_WIDTH-1:0] pins_raw;
   logic [SYNC_WIDTH-1:0] pins_sync;
   logic nmi_prev;
   logic nmi_latched;
   logic [NUM_LINES-1:0] line_prev;
   logic [NUM_LINES-1:0] edge_pending;
   logic [NUM_LINES-1:0] line_level;
   logic [NUM_LINES-1:0] line_is_input;
   logic [NUM_LINES-1:0] line_request;
   logic [NUM_LINES-1:0] line_rise;
   logic [NUM_LINES-1:0] take_onehot;
   // take sequencing
   take_state_t state;
   logic [ACK_CNT_W-1:0] ack_count;
   logic [1:0] service_line;
   logic take_nmi_now;
   logic take_mask_now;
   logic [1:0] win_line;
   logic line_win;
   logic ack_zero_active;
   logic ack_one_active;
   logic address_phase;
   logic wr_en;
   logic [EVT_WIDTH-1:0] evt_set;

   // lowest numbered requesting line wins among maskable lines
   function automatic logic [1:0] lowest_line(input logic [NUM_LINES-1:0] req);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = NUM_LINES - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction : lowest_line

   // register read decode
   function automatic logic [31:0] read_word(input logic [7:0] addr,
                                            input logic [CFG_WIDTH-1:0] cfg,
                                            input logic [NUM_LINES-1:0] en,
                                            input logic [EVT_WIDTH-1:0] pend,
                                            input logic [EVT_WIDTH-1:0] stat,
                                            input logic [EVT_WIDTH-1:0] msk,
                                            input logic [7:0] vbase,
                                            input logic [SYNC_WIDTH-1:0] raw);
      logic [31:0] word;
      word = RDATA_ZERO;
      case (addr)
         OFS_CONFIG: word[CFG_WIDTH-1:0] = cfg;
         OFS_ENABLE: word[NUM_LINES-1:0] = en;
         OFS_PENDING: word[EVT_WIDTH-1:0] = pend;
         OFS_EVT_STATUS: word[EVT_WIDTH-1:0] = stat;
         OFS_EVT_MASK: word[EVT_WIDTH-1:0] = msk;
         OFS_VECTOR_BASE: word[7:0] = vbase;
         OFS_RAW: word[SYNC_WIDTH-1:0] = raw;
         default: word = RDATA_ZERO;
      endcase
      return word;
   endfunction : read_word

   // all pins pass two flops; bit 0 is the non-maskable line
   assign pins_raw = {request_three_or_ack_one_in, request_two_or_ack_zero_in,
                      maskable_request_one, maskable_request_zero, nmi_request};

   pin_sync u_pin_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in(pins_raw),
      .sync_out(pins_sync)
   );

   // slave mode removes lines one to three as direct inputs; ack mode removes two, three
   always_comb begin
      line_is_input = {NUM_LINES{1'b1}};
      if (config_reg[CFG_ACK_TWO]) begin
         line_is_input[2] = 1'b0;
      end
      if (config_reg[CFG_ACK_THREE]) begin
         line_is_input[3] = 1'b0;
      end
      if (config_reg[CFG_SLAVE]) begin
         line_is_input[3:1] = 3'h0;
      end
   end

   assign line_level = pins_sync[SYNC_WIDTH-1:1];
   assign line_rise = line_level & ~line_prev;

   // per line edge or level selection
   genvar g;
   generate
      for (g = 0; g < NUM_LINES; g++) begin : g_line
         assign line_request[g] = line_is_input[g] & enable_reg[g] &
                                  (config_reg[CFG_LEVEL_LSB + g] ? line_level[g]
                                                                 : edge_pending[g]);
      end
   endgenerate

   // edge capture of the non-maskable line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_prev <= 1'b0;
         nmi_latched <= 1'b0;
      end else begin
         nmi_prev <= pins_sync[EVT_NMI];
         if (pins_sync[EVT_NMI] && !nmi_prev) begin
            nmi_latched <= 1'b1;
         end else if (take_nmi_now) begin
            nmi_latched <= 1'b0;
         end
      end
   end

   // edge capture of maskable lines, cleared when the line is taken
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_prev <= '0;
         edge_pending <= '0;
      end else begin
         line_prev <= line_level;
         edge_pending <= (edge_pending & ~take_onehot) |
                         (line_rise & line_is_input);
      end
   end

   // boundary decisions; the non-maskable request is never gated by software
   assign take_nmi_now = instr_boundary & nmi_latched;
   assign line_win = |line_request;
   assign win_line = lowest_line(line_request);
   assign take_mask_now = instr_boundary & ~nmi_latched & line_win &
                          (state == st_idle);
   assign take_onehot = take_mask_now ? (NUM_LINES'(1) << win_line) : '0;

   // take sequencer: idle, acknowledge strobe, in service
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= st_idle;
         ack_count <= ACK_ZERO;
         service_line <= 2'h0;
      end else begin
         case (state)
            st_idle: begin
               if (take_mask_now) begin
                  service_line <= win_line;
                  ack_count <= ACK_ZERO;
                  if ((win_line == 2'h0 && config_reg[CFG_ACK_TWO]) ||
                      (win_line == 2'h1 && config_reg[CFG_ACK_THREE])) begin
                     state <= st_ack;
                  end else begin
                     state <= st_service;
                  end
               end
            end
            st_ack: begin
               if (ack_count == ACK_LAST) begin
                  state <= st_service;
               end else begin
                  ack_count <= ack_count + 4'h1;
               end
            end
            st_service: begin
               if (end_of_service) begin
                  state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // take outputs to the core, one cycle after the boundary
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         take_valid <= 1'b0;
         take_nmi <= 1'b0;
         take_vector <= 8'h00;
      end else begin
         take_valid <= take_nmi_now | take_mask_now;
         take_nmi <= take_nmi_now;
         if (take_nmi_now) begin
            take_vector <= NMI_VECTOR;
         end else if (take_mask_now) begin
            take_vector <= vector_base + {6'h00, win_line};
         end
      end
   end

   // acknowledge strobes, active low while the strobe state runs
   assign ack_zero_active = (state == st_ack) && (service_line == 2'h0);
   assign ack_one_active = (state == st_ack) && (service_line == 2'h1);

   // pin drivers: ack outputs idle high; slave mode forwards line zero upward
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         request_two_or_ack_zero_out <= 1'b1;
         request_two_or_ack_zero_oe <= 1'b0;
         request_three_or_ack_one_out <= 1'b1;
         request_three_or_ack_one_oe <= 1'b0;
      end else begin
         request_two_or_ack_zero_oe <= config_reg[CFG_ACK_TWO];
         request_two_or_ack_zero_out <= ~ack_zero_active;
         if (config_reg[CFG_SLAVE]) begin
            request_three_or_ack_one_oe <= 1'b1;
            request_three_or_ack_one_out <= line_request[0];
         end else begin
            request_three_or_ack_one_oe <= config_reg[CFG_ACK_THREE];
            request_three_or_ack_one_out <= ~ack_one_active;
         end
      end
   end

   // ahb-lite address phase capture; zero wait states, always okay
   assign address_phase = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_en = dp_write & hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hrdata <= RDATA_ZERO;
      end else begin
         dp_write <= address_phase & hwrite;
         if (address_phase) begin
            dp_addr <= haddr[7:0];
         end
         if (address_phase && !hwrite) begin
            hrdata <= (haddr[31:8] == 24'h000000) ?
                      read_word(haddr[7:0], config_reg, enable_reg,
                                {line_request, nmi_latched}, evt_status, evt_mask,
                                vector_base, pins_sync) : RDATA_ZERO;
         end
      end
   end

   // configuration registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         config_reg <= CONFIG_RESET;
         enable_reg <= ENABLE_RESET;
         evt_mask <= EVT_MASK_RESET;
         vector_base <= VECTOR_BASE_RESET;
      end else if (wr_en) begin
         case (dp_addr)
            OFS_CONFIG: config_reg <= hwdata[CFG_WIDTH-1:0];
            OFS_ENABLE: enable_reg <= hwdata[NUM_LINES-1:0];
            OFS_EVT_MASK: evt_mask <= hwdata[EVT_WIDTH-1:0];
            OFS_VECTOR_BASE: vector_base <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // sticky events, write one to clear; a new event wins over the clear
   assign evt_set = {line_rise & line_is_input,
                     pins_sync[EVT_NMI] & ~nmi_prev};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         evt_status <= '0;
      end else if (wr_en && dp_addr == OFS_EVT_STATUS) begin
         evt_status <= (evt_status & ~hwdata[EVT_WIDTH-1:0]) | evt_set;
      end else begin
         evt_status <= evt_status | evt_set;
      end
   end

   // level interrupt while any unmasked event is set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(evt_status & evt_mask);
      end
   end
endmodule : interrupt_request_front_end

// ==== verilog/irq_front_sync.sv ====
// Overview of operation
// - an accepted non-maskable request is taken with vector type 2.
// - a rising edge on the non-maskable line is synchronized and latched.
// - a latched non-maskable request is taken only at an instruction boundary.
// - the non-maskable request has no mask; every latched edge is taken.
// - maskable request inputs are active high, as level or rising edge.
// - every maskable request input is synchronized before any logic uses it.
// - lines two and three can instead drive active-low acknowledge strobes.
// - each maskable line is edge- or level-triggered, set independently.
// - slave configuration changes the request pins away from direct inputs.
// - reset abandons activity, clears latches and configuration except vector base (8'h08), returns idle.
`timescale 1ns/1ps
package irq_front_pkg;
   localparam int NUM_LINES = 4;
   localparam int SYNC_WIDTH = 5;
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_ENABLE = 8'h04;
   localparam logic [7:0] OFS_PENDING = 8'h08;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h0C;
   localparam logic [7:0] OFS_EVT_MASK = 8'h10;
   localparam logic [7:0] OFS_VECTOR_BASE = 8'h14;
   localparam logic [7:0] OFS_RAW = 8'h18;
   // config field positions
   localparam int CFG_LEVEL_LSB = 0;
   localparam int CFG_ACK_TWO = 4;
   localparam int CFG_ACK_THREE = 5;
   localparam int CFG_SLAVE = 6;
   localparam int CFG_WIDTH = 7;
   // event and pending layout: bit 0 non-maskable, bits 4:1 maskable lines
   localparam int EVT_WIDTH = 5;
   localparam int EVT_NMI = 0;
   localparam int EVT_LINE_LSB = 1;
   // reset values
   localparam logic [CFG_WIDTH-1:0] CONFIG_RESET = 7'h00;
   localparam logic [NUM_LINES-1:0] ENABLE_RESET = 4'h0;
   localparam logic [EVT_WIDTH-1:0] EVT_MASK_RESET = 5'h00;
   localparam logic [7:0] VECTOR_BASE_RESET = 8'h08;
   // vector of the non-maskable request
   localparam logic [7:0] NMI_VECTOR = 8'h02;
   // acknowledge strobe timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int ACK_TIME_NS = 100;
   localparam int ACK_CYCLES_RAW = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_CYCLES = (ACK_CYCLES_RAW < 1) ? 1 : ACK_CYCLES_RAW;
   localparam int ACK_CNT_W = 4;
   localparam logic [ACK_CNT_W-1:0] ACK_LAST = ACK_CNT_W'(ACK_CYCLES - 1);
   localparam logic [ACK_CNT_W-1:0] ACK_ZERO = 4'h0;
   // ahb constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {
      st_idle,
      st_ack,
      st_service
   } take_state_t;
endpackage : irq_front_pkg

// two-flop synchronizer for pin inputs
module pin_sync
   import irq_front_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [SYNC_WIDTH-1:0] async_in,
   output logic [SYNC_WIDTH-1:0] sync_out
);
   logic [SYNC_WIDTH-1:0] meta;

   // first stage read only by the second stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : pin_sync

// ==== tb/irq_front_monitor.sv ====
`timescale 1ns/1ps
module irq_front_monitor
   import irq_front_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic nmi_request,
   input wire logic instr_boundary,
   input wire logic request_two_or_ack_zero_out,
   input wire logic request_two_or_ack_zero_oe,
   input wire logic request_three_or_ack_one_out,
   input wire logic request_three_or_ack_one_oe,
   input wire logic take_valid,
   input wire logic take_nmi,
   input wire logic [7:0] take_vector,
   input wire logic irq
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [2:0] quiet;
   // edges since the last nmi rise with no boundary in between, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) quiet <= 3'h0;
      else if ($rose(nmi_request)) quiet <= 3'h1;
      else if (instr_boundary) quiet <= 3'h0;
      else if (quiet != 3'h0 && quiet != 3'h7) quiet <= quiet + 3'h1;
   end
   // second low cycle of the strobe, then back to idle high
   sequence ack_pulse;
      !request_two_or_ack_zero_out ##1 request_two_or_ack_zero_out;
   endsequence
   nmi_taken_a: assert property (instr_boundary && quiet >= 3'h4 |=> take_valid && take_nmi)
      else $error("latched nmi edge not taken at boundary");
   nmi_vector_a: assert property (take_valid && take_nmi |-> take_vector == NMI_VECTOR)
      else $error("nmi taken with wrong vector");
   take_boundary_a: assert property (take_valid |-> $past(instr_boundary))
      else $error("take without a boundary");
   ack_strobe_a: assert property ($fell(request_two_or_ack_zero_out) |-> request_two_or_ack_zero_oe ##1 ack_pulse)
      else $error("ack strobe shape wrong");
   idle_two_a: assert property (!request_two_or_ack_zero_oe |-> request_two_or_ack_zero_out)
      else $error("pin two out not idle high");
   idle_three_a: assert property (!request_three_or_ack_one_oe |-> request_three_or_ack_one_out)
      else $error("pin three out not idle high");
   vector_hold_a: assert property (!take_valid |-> $stable(take_vector))
      else $error("vector changed without a take");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   reset_idle_a: assert property (disable iff (1'b0) !hresetn |-> !take_valid && !irq && !request_two_or_ack_zero_oe)
      else $error("outputs not idle in reset");
endmodule : irq_front_monitor
bind interrupt_request_front_end irq_front_monitor i_irq_front_monitor (
   .hclk, .hresetn, .hreadyout, .hresp, .nmi_request, .instr_boundary,
   .request_two_or_ack_zero_out, .request_two_or_ack_zero_oe,
   .request_three_or_ack_one_out, .request_three_or_ack_one_oe,
   .take_valid, .take_nmi, .take_vector, .irq
);

// ==== tb/irq_partner.sv ====
`timescale 1ns/1ps
module irq_partner (
   input wire logic hclk,
   input wire logic fire_nmi,
   input wire logic [3:0] raise,
   input wire logic ack_zero_n,
   input wire logic ack_one_n,
   input wire logic ack_zero_en,
   input wire logic ack_one_en,
   output logic nmi_request,
   output logic [3:0] line_req
);
   logic [1:0] nmi_left = 2'h0;
   logic [3:0] held = 4'h0;
   // the nmi line stays high two clock periods after each fire
   always_ff @(posedge hclk) begin
      if (fire_nmi) nmi_left <= 2'h2;
      else if (nmi_left != 2'h0) nmi_left <= nmi_left - 2'h1;
   end
   assign nmi_request = (nmi_left != 2'h0);
   // a request with a live ack pin stays up until its strobe is seen; others follow raise
   always_ff @(posedge hclk) begin
      held <= raise | (held & {2'h0, ack_one_en & ack_one_n, ack_zero_en & ack_zero_n});
   end
   assign line_req = held;
endmodule : irq_partner

// ==== tb/interrupt_request_front_end_tb.sv ====
`timescale 1ns/1ps
module interrupt_request_front_end_tb;
   import irq_front_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, nmi_request, fire_nmi;
   logic instr_boundary, end_of_service, take_valid, take_nmi, irq;
   logic out2, oe2, out3, oe3, p2, p3;
   logic [1:0] htrans, strobe;
   logic [3:0] raise, line_req;
   logic [7:0] take_vector;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [31:0] offs [8] = '{32'h0, 32'h4, 32'h8, 32'hC, 32'h10, 32'h14, 32'h1C, 32'h100};
   logic [31:0] exps [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0};
   int fail_count, checks_done;
   // shared pins resolve between the block and the requesters
   assign p2 = oe2 ? out2 : line_req[2];
   assign p3 = oe3 ? out3 : line_req[3];
   assign fire_nmi = strobe[0];
   assign end_of_service = strobe[1];
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   interrupt_request_front_end i_interrupt_request_front_end (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .nmi_request,
      .maskable_request_zero(line_req[0]), .maskable_request_one(line_req[1]),
      .request_two_or_ack_zero_in(p2), .request_two_or_ack_zero_out(out2),
      .request_two_or_ack_zero_oe(oe2), .request_three_or_ack_one_in(p3),
      .request_three_or_ack_one_out(out3), .request_three_or_ack_one_oe(oe3),
      .instr_boundary, .end_of_service, .take_valid, .take_nmi, .take_vector, .irq
   );
   irq_partner i_irq_partner (
      .hclk, .fire_nmi, .raise, .ack_zero_n(oe2 ? out2 : 1'b1),
      .ack_one_n(oe3 ? out3 : 1'b1), .ack_zero_en(oe2), .ack_one_en(oe3),
      .nmi_request, .line_req
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         $display("Error %0t %s", $time, what);
         fail_count++;
      end
   endtask : chk
   // one single transfer; read data is taken at the edge ending the data phase
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
      bus(a, 1'b0, 32'h0);
      chk(rd, exp, what);
   endtask : rdchk
   task automatic pulse(input logic [1:0] s);
      @(posedge hclk);
      strobe <= s;
      @(posedge hclk);
      strobe <= 2'h0;
   endtask : pulse
   // pulse one boundary and watch for the take that answers it
   task automatic take(input logic exp_seen, input logic exp_nmi, input logic [7:0] exp_vec);
      logic seen;
      logic nmi_got;
      logic [7:0] vec;
      seen = 1'b0;
      nmi_got = 1'b0;
      vec = 8'h00;
      @(posedge hclk);
      instr_boundary <= 1'b1;
      @(posedge hclk);
      instr_boundary <= 1'b0;
      repeat (3) begin
         @(posedge hclk);
         if (take_valid === 1'b1) begin
            seen = 1'b1;
            nmi_got = take_nmi;
            vec = take_vector;
         end
      end
      chk(32'(seen), 32'(exp_seen), "take seen");
      if (exp_seen) begin
         chk(32'(nmi_got), 32'(exp_nmi), "take kind");
         chk(32'(vec), 32'(exp_vec), "take vector");
      end
   endtask : take
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // watchdog against a hung handshake
   initial begin
      #100us;
      fail_count++;
      print_verdict();
   end
   initial begin
      hresetn <= 1'b0;
      {hsel, hwrite, instr_boundary, strobe, htrans, raise} = '0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (offs[i]) rdchk(offs[i], exps[i], "reset value");
      $display("test reset values done");
      pulse(2'h1);
      repeat (6) @(posedge hclk);
      rdchk(32'h8, 32'h1, "nmi latched");
      take(1'b1, 1'b1, NMI_VECTOR);
      rdchk(32'h8, 32'h0, "nmi latch cleared");
      pulse(2'h2);
      bus(32'hC, 1'b1, 32'h1F);
      $display("test nmi done");
      bus(32'h0, 1'b1, 32'h12);
      bus(32'h4, 1'b1, 32'h3);
      @(posedge hclk);
      raise <= 4'h3;
      @(posedge hclk);
      raise <= 4'h2;
      repeat (5) @(posedge hclk);
      rdchk(32'h18, 32'hE, "raw pins");
      rdchk(32'h8, 32'h6, "line pending");
      chk(32'(irq), 32'h0, "irq masked");
      bus(32'h10, 1'b1, 32'h6);
      repeat (2) @(posedge hclk);
      chk(32'(irq), 32'h1, "irq raised");
      take(1'b1, 1'b0, 8'h08);
      take(1'b0, 1'b0, 8'h00);
      rdchk(32'h18, 32'hC, "request released on ack");
      pulse(2'h2);
      bus(32'h14, 1'b1, 32'h40);
      pulse(2'h1);
      repeat (6) @(posedge hclk);
      take(1'b1, 1'b1, NMI_VECTOR);
      pulse(2'h2);
      take(1'b1, 1'b0, 8'h41);
      pulse(2'h2);
      raise <= 4'h0;
      repeat (5) @(posedge hclk);
      take(1'b0, 1'b0, 8'h00);
      bus(32'hC, 1'b0, 32'h0);
      chk(rd & 32'h7, 32'h7, "events latched");
      bus(32'hC, 1'b1, 32'h1F);
      rdchk(32'hC, 32'h0, "events cleared");
      chk(32'(irq), 32'h0, "irq cleared");
      $display("test maskable lines done");
      bus(32'h0, 1'b1, 32'h40);
      repeat (2) @(posedge hclk);
      chk(32'(oe3), 32'h1, "slave pin drive");
      chk(32'(oe2), 32'h0, "ack pin released");
      chk(32'(out3), 32'h0, "slave pin idle");
      raise <= 4'h1;
      repeat (7) @(posedge hclk);
      chk(32'(out3), 32'h1, "slave pin forwards line zero");
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      chk(32'(oe3), 32'h0, "pin released in reset");
      rdchk(32'h0, 32'h0, "config cleared");
      rdchk(32'h14, 32'h8, "base restored");
      $display("test slave and reset done");
      print_verdict();
   end
endmodule : interrupt_request_front_end_tb
